// *** src/rate_measure_pkg.sv ***
/*
  constants and carrier types for the auto rate measurement block.
  assumes a single 200 MHz clock and an apb slave register port.
*/
package rate_measure_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] div_low_off = 8'h04;
  localparam logic [7:0] div_high_off = 8'h08;
  localparam logic [7:0] rxbuf_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int measure_en_bit = 0;
  localparam int wake_en_bit = 1;
  localparam int wide_div_bit = 3;
  localparam int high_speed_bit = 4;
  localparam int sync_mode_bit = 5;
  localparam int rollover_bit = 7;

  // status register fields
  localparam int rx_complete_bit = 0;
  localparam int rx_idle_bit = 1;
  localparam int tx_blocked_bit = 2;
  localparam int measuring_bit = 3;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [15:0] divisor_reset = 16'h0000;
  localparam logic [15:0] counter_reset = 16'h0000;
  localparam logic [8:0] prescale_reset = 9'h000;
  localparam logic [2:0] edge_reset = 3'h0;
  localparam logic [2:0] last_edge = 3'h5;
  localparam logic [8:0] div512_last = 9'h1ff;
  localparam logic [8:0] div128_last = 9'h07f;
  localparam logic [8:0] div32_last = 9'h01f;

  typedef enum {st_idle, st_wait_start, st_wait_rise, st_count} measure_state_t;

  typedef struct packed {
    logic measure_en;
    logic wake_en;
    logic wide_div;
    logic high_speed;
    logic sync_mode;
  } rate_cfg_t;

endpackage

// *** src/uart_auto_baud_detect.sv ***
/*
  auto rate measurement for the serial port unit, with apb register access.
  assumes rx_pin is asynchronous; the receive and transmit datapaths sit
  outside and obey rx_hold and tx_blocked.
*/
// Function
// RULE1 - measure only in asynchronous mode
// RULE2 - sequence starts on a start bit while measurement enabled
// RULE3 - enabling measurement clears the counter, then waits for start bit
// RULE4 - remote sends 55h sync character
// RULE5 - both low and high bit times are timed for averaging
// RULE6 - counting begins at the first rising edge after start bit
// RULE7 - at fifth rising edge count stays in divisor register pair
// RULE8 - measurement enable cleared by hardware at fifth rising edge
// RULE9 - counter wrap from ffff to 0000 sets rollover flag
// RULE10 - hardware sets rollover flag; software may write it either way
// RULE11 - rollover leaves measurement running and enable set
// RULE12 - counter advances at one eighth of normal configured clock (code: pclk/512, /128 or /32; rate generator counts every pclk)
// RULE13 - counter clock is /512, /128 or /32 from the two selects
// RULE14 - both divisor bytes form one 16-bit counter while measuring
// RULE15 - in narrow mode software checks high byte is 00h
// RULE16 - normal receiver held idle during measurement
// RULE17 - receive-complete flag set at fifth rising edge
// RULE18 - reading receive buffer clears receive-complete; value discarded
// RULE19 - with wake-on-break set, measure the character after the break
// RULE20 - software must not write transmit buffer while measuring
// RULE21 - software avoids enabling measurement during transmission
// RULE22 - software keeps incoming rate within measurable range
// RULE23 - after measurement the counter free-runs with captured reload
`timescale 1ns/10ps
module uart_auto_baud_detect (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and datapath hooks
  input wire logic rx_pin,
  input wire logic break_seen,
  output logic rx_hold,
  output logic tx_blocked,
  output logic rate_tick
);

  // ****************************************
  // input sync and edges
  // ****************************************
  logic rx_meta_r, rx_sync_r, rx_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end
  wire logic rx_fall = rx_prev_r & ~rx_sync_r;
  wire logic rx_rise = ~rx_prev_r & rx_sync_r;

  // ****************************************
  // registers
  // ****************************************
  rate_measure_pkg::rate_cfg_t cfg_r;
  rate_measure_pkg::measure_state_t state_r;
  logic [15:0] divisor_r, count_r;
  logic [8:0] pre_r;
  logic [2:0] edges_r;
  logic rollover_r, rx_complete_r, armed_r, break_done_r;

  wire logic apb_acc = psel & penable;
  wire logic wr = apb_acc & pwrite;
  wire logic rd = apb_acc & ~pwrite;
  wire logic ctrl_wr = wr && paddr == rate_measure_pkg::ctrl_off;
  wire logic allowed = ~cfg_r.sync_mode; // RULE1
  wire logic measuring = state_r == rate_measure_pkg::st_count;
  wire logic fifth = measuring && rx_rise
      && edges_r == rate_measure_pkg::last_edge - 3'h1;

  function automatic logic [8:0] pre_last(input logic wide, input logic fast);
    case ({wide, fast})
      2'b00: pre_last = rate_measure_pkg::div512_last; // RULE13
      2'b11: pre_last = rate_measure_pkg::div32_last;
      default: pre_last = rate_measure_pkg::div128_last;
    endcase
  endfunction

  wire logic pre_tick = pre_r == pre_last(cfg_r.wide_div, cfg_r.high_speed);
  wire logic [15:0] count_inc = count_r + 16'h0001;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '0;
    end else if (ctrl_wr) begin
      cfg_r.measure_en <= pwdata[rate_measure_pkg::measure_en_bit];
      cfg_r.wake_en <= pwdata[rate_measure_pkg::wake_en_bit];
      cfg_r.wide_div <= pwdata[rate_measure_pkg::wide_div_bit];
      cfg_r.high_speed <= pwdata[rate_measure_pkg::high_speed_bit];
      cfg_r.sync_mode <= pwdata[rate_measure_pkg::sync_mode_bit];
    end else if (fifth) begin
      cfg_r.measure_en <= 1'b0; // RULE8
    end
  end

  // ****************************************
  // measurement state machine
  // ****************************************
  // wake-on-break: wait for the break before looking for the start bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rate_measure_pkg::st_idle;
      edges_r <= rate_measure_pkg::edge_reset;
      break_done_r <= 1'b0;
    end else begin
      case (state_r)
        rate_measure_pkg::st_idle: begin
          break_done_r <= 1'b0;
          if (cfg_r.measure_en && allowed) begin
            state_r <= rate_measure_pkg::st_wait_start; // RULE3
          end
        end
        rate_measure_pkg::st_wait_start: begin
          if (cfg_r.wake_en && !break_done_r) begin
            if (break_seen) begin
              break_done_r <= 1'b1; // RULE19
            end
          end else if (rx_fall) begin
            state_r <= rate_measure_pkg::st_wait_rise; // RULE2
          end
          if (!cfg_r.measure_en) begin
            state_r <= rate_measure_pkg::st_idle;
          end
        end
        rate_measure_pkg::st_wait_rise: begin
          if (rx_rise) begin
            state_r <= rate_measure_pkg::st_count; // RULE6
            edges_r <= 3'h1;
          end
          if (!cfg_r.measure_en) begin
            state_r <= rate_measure_pkg::st_idle;
          end
        end
        rate_measure_pkg::st_count: begin
          if (rx_rise) begin
            edges_r <= edges_r + 3'h1; // RULE5
          end
          if (fifth || !cfg_r.measure_en) begin
            state_r <= rate_measure_pkg::st_idle; // RULE7
            edges_r <= rate_measure_pkg::edge_reset;
          end
        end
        default: state_r <= rate_measure_pkg::st_idle;
      endcase
    end
  end

  // ****************************************
  // rate generator / counter
  // ****************************************
  // prescaler gives the measuring clock: pclk divided by 512, 128 or 32 per the two selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= rate_measure_pkg::prescale_reset;
    end else if (!measuring || pre_tick) begin
      pre_r <= rate_measure_pkg::prescale_reset; // RULE12
    end else begin
      pre_r <= pre_r + 9'h001;
    end
  end

  // one 16-bit counter; divisor_r holds the count, so it lands in place
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_r <= rate_measure_pkg::divisor_reset;
    end else if (state_r == rate_measure_pkg::st_idle && cfg_r.measure_en && allowed) begin
      divisor_r <= rate_measure_pkg::divisor_reset; // RULE3
    end else if (measuring && pre_tick && !fifth) begin
      divisor_r <= divisor_r + 16'h0001; // RULE14
    end else if (!cfg_r.measure_en && wr && paddr == rate_measure_pkg::div_low_off) begin
      divisor_r[7:0] <= pwdata[7:0];
    end else if (!cfg_r.measure_en && wr && paddr == rate_measure_pkg::div_high_off) begin
      divisor_r[15:8] <= pwdata[7:0];
    end
  end

  // free-running rate generation with the captured reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= rate_measure_pkg::counter_reset;
      rate_tick <= 1'b0;
    end else if (cfg_r.measure_en || count_r == divisor_r) begin
      count_r <= rate_measure_pkg::counter_reset; // RULE23
      rate_tick <= ~cfg_r.measure_en;
    end else begin
      count_r <= count_inc;
      rate_tick <= 1'b0;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  wire logic wrap = measuring && pre_tick && !fifth && divisor_r == 16'hffff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rollover_r <= 1'b0;
    end else if (wrap) begin
      rollover_r <= 1'b1; // RULE9 RULE11
    end else if (ctrl_wr) begin
      rollover_r <= pwdata[rate_measure_pkg::rollover_bit]; // RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_complete_r <= 1'b0;
    end else if (fifth) begin
      rx_complete_r <= 1'b1; // RULE17
    end else if (rd && paddr == rate_measure_pkg::rxbuf_off) begin
      rx_complete_r <= 1'b0; // RULE18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold <= 1'b0;
      tx_blocked <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      armed_r <= cfg_r.measure_en && allowed;
      rx_hold <= (cfg_r.measure_en && allowed) || fifth; // RULE16
      tx_blocked <= cfg_r.measure_en; // RULE20
    end
  end

  // ****************************************
  // apb read side
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          rate_measure_pkg::ctrl_off: prdata <= {24'h000000, rollover_r, 1'b0,
              cfg_r.sync_mode, cfg_r.high_speed, cfg_r.wide_div, 1'b0,
              cfg_r.wake_en, cfg_r.measure_en};
          rate_measure_pkg::div_low_off: prdata <= {24'h000000, divisor_r[7:0]};
          rate_measure_pkg::div_high_off: prdata <= {24'h000000, divisor_r[15:8]};
          rate_measure_pkg::rxbuf_off: prdata <= 32'h0000_0000;
          rate_measure_pkg::status_off: prdata <= {28'h0000000, measuring,
              cfg_r.measure_en, ~armed_r, rx_complete_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  fifth_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
      fifth |=> !cfg_r.measure_en && rx_complete_r) // RULE8
    else $error("fifth edge did not clear enable or set complete");
  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap |=> rollover_r && cfg_r.measure_en) // RULE9
    else $error("rollover not trapped");
  hold_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
      measuring |=> rx_hold) // RULE16
    else $error("receiver not held during measurement");
  start_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == rate_measure_pkg::st_wait_start |-> divisor_r == 16'h0000) // RULE3
    else $error("counter not cleared before start bit");
  sync_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_r.sync_mode |-> !measuring) // RULE1
    else $error("measurement in synchronous mode");
  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == rate_measure_pkg::st_wait_rise |=> $stable(divisor_r)) // RULE6
    else $error("counting before first rising edge");
  rd_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == rate_measure_pkg::rxbuf_off && !fifth |=> !rx_complete_r) // RULE18
    else $error("buffer read did not clear complete");
  tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      measuring && pre_tick && !cfg_r.wide_div && !cfg_r.high_speed
      |-> pre_r == rate_measure_pkg::div512_last) // RULE13
    else $error("prescale not divide by 512");

endmodule // uart_auto_baud_detect

// *** tb/serial_sender.sv ***
/*
  remote serial transmitter that sends framed characters on the receive line.
  assumes the bench gives the bit time in pclk cycles; the line idles high.
*/
`timescale 1ns/10ps
module serial_sender (
  // clock
  input wire logic pclk,
  // serial line
  output logic rx_line
);
  initial begin
    rx_line = 1'b1;
  end

  // ****************************************
  // one frame: start bit, eight bits lsb first, stop bit
  // ****************************************
  // the line goes back to its idle high level after the stop bit
  task automatic send(input logic [7:0] ch, input int bit_cycles);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(posedge pclk);
      rx_line <= frame[b];
      repeat (bit_cycles - 1) @(posedge pclk);
    end
  endtask
endmodule // serial_sender

// *** tb/tb.sv ***
/*
  self-checking bench for the auto rate measurement block.
  assumes the block answers apb within the bench timeout and that
  serial_sender stands for the remote transmitter.
*/
`timescale 1ns/10ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, break_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rx_pin, rx_hold, tx_blocked, rate_tick, err;
  int fails, cmp_count, cycles, n;
  logic [31:0] exp_div, cfg;
  int divs[4] = '{512, 128, 128, 32};
  localparam int bit_cycles = 1024;

  uart_auto_baud_detect dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .break_seen(break_seen), .rx_hold(rx_hold), .tx_blocked(tx_blocked),
    .rate_tick(rate_tick));
  serial_sender tx (.pclk(pclk), .rx_line(rx_pin));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ****************************************
  // apb master and compare helpers
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: five frames of about 10k cycles plus register traffic fit inside this
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      results();
    end
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; break_seen = 1'b0; presetn = 1'b0;
    fails = 0; cmp_count = 0; cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, rate_measure_pkg::ctrl_off, 0); chk(rd, 32'h0000_0000);
    apb(0, 8'h3c, 0); chk({31'h0, err}, 32'h0000_0001);
    apb(1, rate_measure_pkg::ctrl_off, 32'h0000_0080);
    apb(0, rate_measure_pkg::ctrl_off, 0); chk(rd, 32'h0000_0080);
    apb(1, rate_measure_pkg::ctrl_off, 32'h0000_0000);
    apb(0, rate_measure_pkg::ctrl_off, 0); chk(rd, 32'h0000_0000);
    // sync mode must not start a measurement
    apb(1, rate_measure_pkg::ctrl_off, 32'h0000_0021);
    tx.send(8'h55, bit_cycles);
    apb(0, rate_measure_pkg::status_off, 0); chk(rd & 32'h1, 32'h0000_0000);
    apb(1, rate_measure_pkg::ctrl_off, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      // last pass measures the character after a break
      cfg = {27'h0, i[1], i[0], 3'b0} | ((i == 3) ? 32'h2 : 32'h0);
      // eight bit times at the counter clock, less one: the divisor is period - 1
      exp_div = 8 * bit_cycles / divs[i] - 1;
      apb(1, rate_measure_pkg::ctrl_off, cfg | 32'h1);
      apb(0, rate_measure_pkg::div_low_off, 0); chk(rd, 32'h0000_0000);
      if (i == 3) begin
        @(posedge pclk); break_seen <= 1'b1;
        @(posedge pclk); break_seen <= 1'b0;
      end
      fork
        tx.send(8'h55, bit_cycles);
        begin
          repeat (3 * bit_cycles) @(posedge pclk);
          chk({30'h0, rx_hold, tx_blocked}, 32'h0000_0003);
        end
      join
      apb(0, rate_measure_pkg::ctrl_off, 0); chk(rd, cfg);
      apb(0, rate_measure_pkg::status_off, 0); chk(rd & 32'h1, 32'h0000_0001);
      apb(0, rate_measure_pkg::div_high_off, 0);
      chk(rd, {24'h0, exp_div[15:8]});
      n = rd;
      apb(0, rate_measure_pkg::div_low_off, 0);
      rd = {n[7:0], rd[7:0]};
      chk(rd, exp_div);
      chk({31'h0, rx_hold}, 32'h0000_0000);
      apb(0, rate_measure_pkg::rxbuf_off, 0); chk(rd, 32'h0000_0000);
      apb(0, rate_measure_pkg::status_off, 0); chk(rd & 32'h1, 32'h0000_0000);
      while (rate_tick !== 1'b1) @(posedge pclk);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rate_tick !== 1'b1);
      chk(n, exp_div + 1);
      chk({31'h0, tx_blocked}, 32'h0000_0000);
    end
    results();
  end
endmodule // tb
